// File: core/rfd_pkg.sv
// constants for the rtc fractional tick divider
//----------------------------------------------------------------------
//----------------------------------------------------------------------
`default_nettype none

package rfd_pkg;
   // register map
   localparam logic [31:0] CFG_ADDR   = 32'h5000_424c;
   localparam int unsigned CFG_W      = 22;
   // field positions
   localparam int unsigned RESET_BIT  = 21;
   localparam int unsigned EN_BIT     = 20;
   localparam int unsigned DENOM_BIT  = 19;
   localparam int unsigned INT_LSB    = 10;
   localparam int unsigned INT_W      = 9;
   localparam int unsigned FRAC_LSB   = 0;
   localparam int unsigned FRAC_W     = 10;
   // reset values
   localparam logic [8:0]  INT_RST    = 9'h147;
   localparam logic [9:0]  FRAC_RST   = 10'h2a8;
   localparam logic [21:0] CFG_RST    = {3'h0, INT_RST, FRAC_RST};
   // sequence lengths
   localparam logic [10:0] DENOM_1000 = 11'h3e8;
   localparam logic [10:0] DENOM_1024 = 11'h400;
endpackage : rfd_pkg

`default_nettype wire

// File: core/rfd_tick_divider.sv
// wishbone configured fractional divider making the rtc 100 Hz tick
//
// The implementer's own choice: the Wishbone slave port.
`default_nettype none

module rfd_tick_divider
   import rfd_pkg::*;
#(
   parameter int ADDR_W = 32
) (
   input  wire logic              ref_clk,
   input  wire logic              reset_n,
   input  wire logic [ADDR_W-1:0] wb_adr_i,
   input  wire logic [31:0]       wb_dat_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic              wb_we_i,
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   output var  logic [31:0]       wb_dat_o,
   output var  logic              wb_ack_o,
   input  wire logic              slowClkEn,
   output var  logic              rtcTick,
   output var  logic              rtcResetReq
);

   //-------------------------------------------------------------------
   // elaboration checks
   //-------------------------------------------------------------------
   if (ADDR_W < 31 || ADDR_W > 32) begin : g_bad_addr
      $error("ADDR_W must be 31 or 32");
   end

   //-------------------------------------------------------------------
   // declarations
   //-------------------------------------------------------------------
   // all assertions run on ref_clk and sleep through reset
   default clocking dcb @(posedge ref_clk);
   endclocking
   default disable iff (!reset_n);

   logic [CFG_W-1:0]  cfg_q,    cfg_d;
   logic [31:0]       rdat_q,   rdat_d;
   logic              ack_q,    ack_d;
   logic [9:0]        cnt_q,    cnt_d;
   logic [9:0]        seq_q,    seq_d;
   logic [10:0]       acc_q,    acc_d;
   logic              tick_q,   tick_d;
   logic              busReq;
   logic              addrHit;
   logic              regWrite;
   logic              enable;
   logic [10:0]       denom;
   logic [INT_W-1:0]  divInt;
   logic [FRAC_W-1:0] frac;
   logic [11:0]       sum;
   logic              extraNow;
   logic [9:0]        periodLen;
   logic [9:0]        lenM1;
   logic              periodEnd;
   logic              seqWrap;
   logic [31:0]       wmask;

   //-------------------------------------------------------------------
   // wishbone slave
   //-------------------------------------------------------------------
   // one request per handshake, answered one cycle after it appears
   assign busReq   = wb_cyc_i & wb_stb_i & ~ack_q;
   assign addrHit  = (wb_adr_i == CFG_ADDR[ADDR_W-1:0]);
   assign regWrite = busReq & wb_we_i & addrHit;

   // byte lane mask from sel
   always_comb begin
      for (int i = 0; i < 4; i++) begin
         wmask[i*8 +: 8] = {8{wb_sel_i[i]}};
      end
   end

   // register file next values
   always_comb begin
      logic [31:0] merged;
      merged = {{(32-CFG_W){1'b0}}, cfg_q};
      cfg_d  = cfg_q;
      rdat_d = rdat_q;
      ack_d  = busReq;
      if (regWrite) begin
         merged = (merged & ~wmask) | (wb_dat_i & wmask);
         cfg_d  = merged[CFG_W-1:0];
      end
      if (busReq) begin
         // unmapped addresses read as zero, writes to them are dropped
         rdat_d = addrHit ? {{(32-CFG_W){1'b0}}, cfg_q} : 32'h0000_0000;
      end
   end

   // register file flops
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cfg_q  <= CFG_RST;
         rdat_q <= 32'h0000_0000;
         ack_q  <= 1'b0;
      end else begin
         cfg_q  <= cfg_d;
         rdat_q <= rdat_d;
         ack_q  <= ack_d;
      end
   end

   assign wb_dat_o    = rdat_q;
   assign wb_ack_o    = ack_q;
   assign rtcResetReq = cfg_q[RESET_BIT];

   //-------------------------------------------------------------------
   // fractional divider
   //-------------------------------------------------------------------
   // field decode
   assign enable = cfg_q[EN_BIT];
   assign denom  = cfg_q[DENOM_BIT] ? DENOM_1024 : DENOM_1000;
   assign divInt = cfg_q[INT_LSB +: INT_W];
   assign frac   = cfg_q[FRAC_LSB +: FRAC_W];

   // this period is long when the accumulator overflows the denominator
   assign sum       = {1'b0, acc_q} + {2'b00, frac};
   assign extraNow  = (sum >= {1'b0, denom});
   assign periodLen = {1'b0, divInt} + {9'h000, extraNow};
   // a zero divisor degrades to one clock per tick
   assign lenM1     = (periodLen == 10'h000) ? 10'h000 : periodLen - 10'h001;
   assign periodEnd = enable & slowClkEn & (cnt_q >= lenM1);
   assign seqWrap   = ({1'b0, seq_q} >= (denom - 11'h001));

   // period and sequence counters
   always_comb begin
      cnt_d  = cnt_q;
      seq_d  = seq_q;
      acc_d  = acc_q;
      tick_d = 1'b0;
      if (!enable) begin
         // held idle so each enable starts a fresh sequence
         cnt_d = 10'h000;
         seq_d = 10'h000;
         acc_d = 11'h000;
      end else if (periodEnd) begin
         cnt_d  = 10'h000;
         tick_d = 1'b1;
         if (seqWrap) begin
            seq_d = 10'h000;
            acc_d = 11'h000;
         end else begin
            seq_d = seq_q + 10'h001;
            acc_d = extraNow ? 11'(sum - {1'b0, denom}) : sum[10:0];
         end
      end else if (slowClkEn) begin
         cnt_d = cnt_q + 10'h001;
      end
   end

   // divider flops
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         cnt_q  <= 10'h000;
         seq_q  <= 10'h000;
         acc_q  <= 11'h000;
         tick_q <= 1'b0;
      end else begin
         cnt_q  <= cnt_d;
         seq_q  <= seq_d;
         acc_q  <= acc_d;
         tick_q <= tick_d;
      end
   end

   assign rtcTick = tick_q;

   //-------------------------------------------------------------------
   // checking helpers
   //-------------------------------------------------------------------
   logic       first_q;
   logic       clean_q;
   logic [9:0] extraCnt_q;

   // reset marker, clean-sequence flag and long period tally
   always_ff @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n) begin
         first_q    <= 1'b1;
         clean_q    <= 1'b0;
         extraCnt_q <= 10'h000;
      end else begin
         first_q <= 1'b0;
         if (!enable) begin
            clean_q <= 1'b1; // idle counters make the next start clean
         end else if (regWrite) begin
            clean_q <= 1'b0; // settings touched inside a running sequence
         end else if (periodEnd && seqWrap) begin
            clean_q <= 1'b1;
         end
         if (!enable || (periodEnd && seqWrap)) begin
            extraCnt_q <= 10'h000;
         end else if (periodEnd) begin
            extraCnt_q <= extraCnt_q + {9'h000, extraNow};
         end
      end
   end

   //-------------------------------------------------------------------
   // assertions
   //-------------------------------------------------------------------
   sequence bus_write_s;
      regWrite && wb_sel_i[2];
   endsequence

   sequence seq_end_s;
      periodEnd && seqWrap;
   endsequence

   tick_gated_a: assert property (
      !enable |=> !rtcTick)
      else $error("tick while divider disabled");

   // a denominator change inside a sequence clears clean_q
   seq_bound_a: assert property (
      clean_q |-> {1'b0, seq_q} < denom)
      else $error("sequence index past denominator");

   int_reset_a: assert property (
      first_q |-> divInt == INT_RST && !rtcTick)
      else $error("integer divisor reset value wrong");

   frac_reset_a: assert property (
      first_q |-> frac == FRAC_RST && !enable)
      else $error("fraction reset value wrong");

   long_count_a: assert property (
      seq_end_s ##0 (clean_q && !regWrite && {1'b0, frac} < denom)
      |-> extraCnt_q + {9'h000, extraNow} == frac)
      else $error("long period count per sequence wrong");

   rst_req_a: assert property (
      bus_write_s ##0 wb_dat_i[RESET_BIT] |=> rtcResetReq ##1 !wb_ack_o)
      else $error("reset request not raised by write");

   rst_req_low_a: assert property (
      first_q |-> !rtcResetReq)
      else $error("reset request not clear after reset");

   seq_restart_a: assert property (
      seq_end_s |=> acc_q == 11'h000 && seq_q == 10'h000)
      else $error("accumulator not restarted at sequence end");

   bus_ack_a: assert property (
      (wb_cyc_i && wb_stb_i && !wb_ack_o) |=> wb_ack_o ##1 !wb_ack_o)
      else $error("bus answer not a single cycle pulse");

endmodule : rfd_tick_divider

`default_nettype wire

// File: tb/rfd_rtc_model.sv
// rtc side model measuring tick periods in slow clock pulses
`default_nettype none
module rfd_rtc_model (
   input  wire logic        ref_clk,
   input  wire logic        reset_n,
   input  wire logic        clr,
   input  wire logic        slowClkEn,
   input  wire logic        rtcTick,
   input  wire logic [8:0]  divInt,
   output var  logic [11:0] tickCount,
   output var  logic [11:0] longCount,
   output var  logic [11:0] badCount
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [11:0] pulses;
   logic [11:0] base;
   assign base = 12'(divInt);
   // a pulse on the tick edge belongs to the next period
   always @(posedge ref_clk or negedge reset_n) begin
      if (!reset_n || clr) begin
         {tickCount, longCount, badCount, pulses} <= '0;
      end else if (rtcTick) begin
         tickCount <= tickCount + 12'h001;
         longCount <= longCount + 12'(pulses == base + 12'h001);
         badCount  <= badCount + 12'(pulses < base || pulses > base + 1);
         pulses    <= 12'(slowClkEn);
      end else begin
         pulses <= pulses + 12'(slowClkEn);
      end
   end
endmodule : rfd_rtc_model
`default_nettype wire

// File: tb/rtc_fractional_tick_divider_bench.sv
// self-checking bench for the rtc fractional tick divider
`default_nettype none
module rtc_fractional_tick_divider_bench;
   import rfd_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic        ref_clk, reset_n, wbWe, wbCyc, wbStb, slowClkEn, clr;
   logic        wbAck, rtcTick, rtcResetReq;
   logic [31:0] wbAdr, wbDatW, wbDatR, rd, v, cfgExp;
   logic [3:0]  wbSel, s;
   logic [8:0]  divInt;
   logic [11:0] tickCount, longCount, badCount, t0;
   int          fails, n_tests;

   rfd_tick_divider dut (.ref_clk(ref_clk), .reset_n(reset_n),
      .wb_adr_i(wbAdr), .wb_dat_i(wbDatW), .wb_sel_i(wbSel), .wb_we_i(wbWe),
      .wb_cyc_i(wbCyc), .wb_stb_i(wbStb), .wb_dat_o(wbDatR),
      .wb_ack_o(wbAck), .slowClkEn(slowClkEn), .rtcTick(rtcTick),
      .rtcResetReq(rtcResetReq));
   rfd_rtc_model rtc (.ref_clk(ref_clk), .reset_n(reset_n), .clr(clr),
      .slowClkEn(slowClkEn), .rtcTick(rtcTick), .divInt(divInt),
      .tickCount(tickCount), .longCount(longCount), .badCount(badCount));

   task automatic check(input string what, input logic [31:0] seen, exp);
      n_tests++;
      if (seen !== exp) begin
         fails++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
      end
   endtask : check

   // one classic cycle, held until ack is sampled
   task automatic wb(input logic [31:0] adr, input logic we,
      input logic [31:0] dat, input logic [3:0] sel);
      int n;
      @(posedge ref_clk);
      {wbAdr, wbWe, wbDatW, wbSel} <= {adr, we, dat, sel};
      {wbCyc, wbStb} <= 2'b11;
      n = 0;
      do begin
         @(posedge ref_clk);
         n++;
      end while (wbAck !== 1'b1 && n < 20);
      if (n >= 20) fails++;
      rd = wbDatR;
      {wbCyc, wbStb} <= 2'b00;
   endtask : wb

   function automatic logic [31:0] cfgWord(input logic rq, en, dn,
      input logic [8:0] dv, input logic [9:0] fr);
      return {10'h000, rq, en, dn, dv, fr};
   endfunction : cfgWord

   // byte lane merge of a write into the expected register value
   function automatic logic [31:0] laneMerge(input logic [31:0] old, dat,
      input logic [3:0] sel);
      logic [31:0] m;
      for (int i = 0; i < 4; i++) begin
         m[i*8 +: 8] = {8{sel[i]}};
      end
      return ((old & ~m) | (dat & m)) & 32'h003f_ffff;
   endfunction : laneMerge

   // one whole sequence from a fresh enable, counting long periods
   task automatic runSeq(input logic dn, input logic [9:0] fr);
      int n;
      divInt = 9'(2 + $urandom % 4);
      wb(CFG_ADDR, 1'b1, cfgWord(1'b0, 1'b0, dn, divInt, fr), 4'hf);
      clr <= 1'b1;
      wb(CFG_ADDR, 1'b1, cfgWord(1'b0, 1'b1, dn, divInt, fr), 4'hf);
      clr <= 1'b0;
      for (n = 0; n < 40000; n++) begin
         @(posedge ref_clk);
         if (tickCount === (dn ? 12'h400 : 12'h3e8)) break;
         slowClkEn <= 1'($urandom);
      end
      slowClkEn <= 1'b0;
      check("ticks", 32'(tickCount), dn ? 32'h400 : 32'h3e8);
      check("long periods", 32'(longCount), 32'(fr));
      check("bad periods", 32'(badCount), 32'h0000_0000);
   endtask : runSeq

   task automatic conclude();
      if (fails == 0 && n_tests > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask : conclude

   initial begin
      ref_clk = 1'b0;
      forever #20 ref_clk = ~ref_clk;
   end

   initial begin
      #(40 * 80000);
      fails++;
      conclude();
   end

   //-------------------------------------------------------------------
   // main sequence
   //-------------------------------------------------------------------
   initial begin
      {reset_n, wbWe, wbCyc, wbStb, slowClkEn, clr} = '0;
      {wbAdr, wbDatW, wbSel} = '0;
      divInt = 9'h147;
      fails = 0;
      n_tests = 0;
      void'($urandom(32'h20fa_adbd));
      repeat (6) @(posedge ref_clk);
      reset_n <= 1'b1;
      wb(CFG_ADDR, 1'b0, 32'h0, 4'hf);
      check("reset cfg", rd, 32'h0005_1ea8);
      check("reset req", 32'(rtcResetReq), 32'h0);
      // unmapped place reads zero and swallows writes
      wb(CFG_ADDR + 4, 1'b1, 32'hffff_ffff, 4'hf);
      wb(CFG_ADDR + 4, 1'b0, 32'h0, 4'hf);
      check("unmapped", rd, 32'h0000_0000);
      wb(CFG_ADDR, 1'b0, 32'h0, 4'hf);
      check("cfg kept", rd, 32'h0005_1ea8);
      // byte lane writes, the first one lane 2 only with all ones
      cfgExp = 32'h0005_1ea8;
      for (int k = 0; k < 8; k++) begin
         v = (k == 0) ? 32'hffff_ffff : $urandom;
         s = (k == 0) ? 4'h4 : 4'($urandom);
         wb(CFG_ADDR, 1'b1, v, s);
         cfgExp = laneMerge(cfgExp, v, s);
         check("reset req", 32'(rtcResetReq), 32'(cfgExp[21]));
         wb(CFG_ADDR, 1'b0, 32'h0, 4'hf);
         check("readback", rd, cfgExp);
      end
      runSeq(1'b0, 10'($urandom % 1000));
      runSeq(1'b1, 10'h3ff);
      runSeq(1'b0, 10'h000);
      // with the enable clear no pulse train yields a tick
      wb(CFG_ADDR, 1'b1, cfgWord(1'b0, 1'b0, 1'b0, divInt, 10'h000), 4'hf);
      t0 = tickCount;
      repeat (60) begin
         @(posedge ref_clk);
         slowClkEn <= 1'b1;
      end
      @(posedge ref_clk);
      slowClkEn <= 1'b0;
      repeat (3) @(posedge ref_clk);
      check("no tick", 32'(tickCount), 32'(t0));
      // reset in mid-run drops the request and restores the register
      wb(CFG_ADDR, 1'b1, cfgWord(1'b1, 1'b1, 1'b1, divInt, 10'h155), 4'hf);
      check("req set", 32'(rtcResetReq), 32'h1);
      reset_n <= 1'b0;
      repeat (2) @(posedge ref_clk);
      reset_n <= 1'b1;
      check("req cleared", 32'(rtcResetReq), 32'h0);
      wb(CFG_ADDR, 1'b0, 32'h0, 4'hf);
      check("reset cfg again", rd, 32'h0005_1ea8);
      conclude();
   end
endmodule : rtc_fractional_tick_divider_bench
`default_nettype wire
